// ### rtl/gtlp_params.svh
`ifndef GTLP_PARAMS_SVH
`define GTLP_PARAMS_SVH

// ****************************************************************
// Clocking
// ****************************************************************
`define GTLP_CLK_HZ       40000000
`define GTLP_BIC_CLK_HZ   1250000
// System clock cycles per half period of the controller clock
`define GTLP_HALF_CNT     (`GTLP_CLK_HZ / `GTLP_BIC_CLK_HZ / 2)

// ****************************************************************
// Control latch bit positions and reset value
// ****************************************************************
`define GTLP_CTL_RFNM     0
`define GTLP_CTL_LMODE    1
`define GTLP_CTL_RSV      2
`define GTLP_CTL_LEN      3
`define GTLP_CTL_NBA      4
`define GTLP_CTL_RST      8'h19

// ****************************************************************
// Interrupt status byte bit positions
// ****************************************************************
`define GTLP_ST_RBV       0
`define GTLP_ST_DCLR      1
`define GTLP_ST_SPOLL     2
`define GTLP_ST_TALK      3
`define GTLP_ST_EOI       4
`define GTLP_ST_HS        5
`define GTLP_ST_LCL       6

// ****************************************************************
// Address shift pattern
// ****************************************************************
`define GTLP_SER_BITS     4'h8
`define GTLP_TALK_ONLY    1'h0

`endif

// ### rtl/gtlp_pkg.sv
`default_nettype none

package gtlp_pkg;

  // ****************************************************************
  // Pin sample vector, synchronised as one group
  // ****************************************************************
  typedef struct packed {
    logic       strb_ctl_n;
    logic       strb_tx_n;
    logic       strb_st_n;
    logic       strb_rx_n;
    logic [7:0] cpu_d;
    logic       rbv;
    logic       dclr;
    logic       lcl;
    logic       spoll;
    logic       talk;
    logic       eoi;
    logic       dav;
    logic       lonly;
    logic [4:0] addr;
    logic [7:0] dio;
  } gtlp_pins_t;

  // State of the core module, except the reset synchroniser
  typedef struct packed {
    gtlp_pins_t s1;
    gtlp_pins_t s2;
    gtlp_pins_t p;
    logic [7:0] ctrl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rd;
    logic       irq;
    logic       dclr;
    logic       eoi;
    logic       hs;
    logic [4:0] div;
    logic       sclk;
    logic       need;
  } gtlp_core_t;

  typedef enum logic [1:0] {
    GTLP_SH_IDLE,
    GTLP_SH_SHIFT,
    GTLP_SH_DONE
  } gtlp_sh_state_t;

  // Whole state of the address shifter
  typedef struct packed {
    gtlp_sh_state_t st;
    logic [7:0]     sr;
    logic [3:0]     cnt;
    logic           data;
    logic           strobe;
  } gtlp_sh_t;

endpackage

`default_nettype wire

// ### rtl/gtlp_shift_if.sv
`default_nettype none

// Link between the core and the address shifter
interface gtlp_shift_if;
  logic       tick;
  logic       sclk;
  logic       start;
  logic [7:0] pattern;
  logic       ser_data;
  logic       ser_strobe;
  logic       busy;

  modport core    (output tick, sclk, start, pattern,
                   input  ser_data, ser_strobe, busy);
  modport shifter (input  tick, sclk, start, pattern,
                   output ser_data, ser_strobe, busy);
endinterface

`default_nettype wire

// ### rtl/gtlp_addr_shifter.sv
`include "gtlp_params.svh"
`default_nettype none

module gtlp_addr_shifter
  import gtlp_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  gtlp_shift_if.shifter  sh
);

  gtlp_sh_t q_r;
  gtlp_sh_t q_nxt;

  // ****************************************************************
  // Serialiser: bit 0 first, data changes before each rising edge
  // ****************************************************************
  always_comb begin
    q_nxt        = q_r;
    q_nxt.strobe = 1'b0;
    case (q_r.st)
      GTLP_SH_IDLE: begin
        if (sh.start) begin
          q_nxt.sr  = sh.pattern;                       // [R3]
          q_nxt.cnt = 4'h0;
          q_nxt.st  = GTLP_SH_SHIFT;
        end
      end
      GTLP_SH_SHIFT: begin
        if (sh.tick && sh.sclk) begin
          if (q_r.cnt == `GTLP_SER_BITS) begin
            q_nxt.strobe = 1'b1;                        // [R3]
            q_nxt.st     = GTLP_SH_DONE;
          end else begin
            q_nxt.data = q_r.sr[0];                     // [R3]
            q_nxt.sr   = {1'b0, q_r.sr[7:1]};
            q_nxt.cnt  = q_r.cnt + 4'h1;
          end
        end
      end
      GTLP_SH_DONE: begin
        q_nxt.st = GTLP_SH_IDLE;
      end
      default: begin
        q_nxt.st = GTLP_SH_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '{st: GTLP_SH_IDLE, sr: 8'h00, cnt: 4'h0, data: 1'b0, strobe: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sh.ser_data   = q_r.data;
  assign sh.ser_strobe = q_r.strobe;
  assign sh.busy       = (q_r.st != GTLP_SH_IDLE);

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_load;
    (q_r.st == GTLP_SH_IDLE) && sh.start;
  endsequence

  sequence s_busy_then_done;
    sh.busy ##1 sh.busy;
  endsequence

  chk_shift_start: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
    s_load |=> s_busy_then_done)
    else $error("shifter did not start on load");

  chk_shift_load: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
    sh.ser_strobe |-> q_r.cnt == `GTLP_SER_BITS ##1 !sh.busy)
    else $error("load strobe without a full pattern");

endmodule

`default_nettype wire

// ### rtl/gtlp_port.sv
`include "gtlp_params.svh"
`default_nettype none

// Overview of operation
// R1: five switches form address, switch one LSB
// R2: operator avoids address codes all zeros, ones
// R3: address shifted serially into bus controller
// R4: no talk-only; listen-only switch passed on
// R5: control bit ready for next message
// R6: listen mode bit selects exclusive talk/listen
// R7: control bit requests service
// R8: listen enable high suppresses received-byte interrupt
// R9: active-low new byte available control bit
// R10: four sources raise the interrupt request
// R11: status read rising edge clears interrupt
// R12: status bit shows received byte valid
// R13: status bit shows device clear received
// R14: status bit follows serial poll enable/disable
// R15: status bit shows talker active state
// R16: status bit set after EOI seen
// R17: handshake bit set on DAV, cleared by new-byte; code sets it only while talker active
// R18: controller and shifters run from 1.25 MHz
// R19: host reset resets controller and board
// R20: output latch captures on strobe, drives bus
// R21: input latch captures on valid, read drives
// R22: falling ready bit starts receive handshake
// R23: service request bit drives bus SRQ
// R24: status bits read as one byte, rest zero

module gtlp_port
  import gtlp_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ctl_write_strobe_n_in,
  input  wire logic       output_latch_write_strobe_n_in,
  input  wire logic       status_read_strobe_n_in,
  input  wire logic       input_latch_read_strobe_n_in,
  input  wire logic [7:0] cpu_data_in,
  output logic      [7:0] cpu_data_out,
  output logic            cpu_data_oe_out,
  output logic            irq_out,
  input  wire logic       address_switch_lsb_in,
  input  wire logic [2:0] address_switch_mid_in,
  input  wire logic       address_switch_msb_in,
  input  wire logic       listen_only_switch_in,
  input  wire logic       received_byte_valid_in,
  input  wire logic       device_clear_in,
  input  wire logic       local_in,
  input  wire logic       serial_poll_in,
  input  wire logic       talker_active_in,
  input  wire logic       eoi_in,
  input  wire logic       dav_in,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            ready_next_n_out,
  output logic            listen_mode_out,
  output logic            service_request_out,
  output logic            new_byte_avail_n_out,
  output logic            bic_clk_out,
  output logic            bic_reset_n_out,
  output logic            addr_ser_data_out,
  output logic            addr_ser_load_out
);

  gtlp_core_t   q_r;
  gtlp_core_t   q_nxt;
  gtlp_pins_t   pins;
  gtlp_pins_t   s;
  gtlp_pins_t   p;
  logic [1:0]   rst_sync_r;
  logic         rst_n;
  logic [7:0]   status;
  logic         rbv_rise;
  logic         src_event;
  logic         st_rise;
  logic         ctl_rise;
  logic         tx_rise;
  logic         hs_set;
  logic         sh_idle;
  gtlp_shift_if sh ();

  // Idle strobes read high, so no false strobe edge follows reset
  localparam gtlp_pins_t pins_idle = '{strb_ctl_n: 1'b1, strb_tx_n: 1'b1, strb_st_n: 1'b1,
                                       strb_rx_n: 1'b1, default: '0};

  // ****************************************************************
  // Reset release
  // ****************************************************************
  // Host reset released through two flip-flops
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n           = rst_sync_r[1];
  assign bic_reset_n_out = rst_n;                       // [R19]

  // ****************************************************************
  // Pin sampling and edge terms
  // ****************************************************************
  // Group every asynchronous input for the two-stage synchroniser
  always_comb begin
    pins            = '0;
    pins.strb_ctl_n = ctl_write_strobe_n_in;
    pins.strb_tx_n  = output_latch_write_strobe_n_in;
    pins.strb_st_n  = status_read_strobe_n_in;
    pins.strb_rx_n  = input_latch_read_strobe_n_in;
    pins.cpu_d      = cpu_data_in;
    pins.rbv        = received_byte_valid_in;
    pins.dclr       = device_clear_in;
    pins.lcl        = local_in;
    pins.spoll      = serial_poll_in;
    pins.talk       = talker_active_in;
    pins.eoi        = eoi_in;
    pins.dav        = dav_in;
    pins.lonly      = listen_only_switch_in;
    pins.addr       = {address_switch_msb_in, address_switch_mid_in,
                       address_switch_lsb_in};          // [R1]
    pins.dio        = bus_data_in;
  end

  assign s        = q_r.s2;
  assign p        = q_r.p;
  assign rbv_rise = s.rbv & ~p.rbv;
  assign st_rise  = s.strb_st_n & ~p.strb_st_n;
  assign ctl_rise = s.strb_ctl_n & ~p.strb_ctl_n;
  assign tx_rise  = s.strb_tx_n & ~p.strb_tx_n;
  assign hs_set   = s.dav & ~p.dav & s.talk;

  // Any enabled source going active drives the flip-flop input high
  assign src_event = (rbv_rise & ~q_r.ctrl[`GTLP_CTL_LEN])       // [R8]
                   | (s.dclr & ~p.dclr)
                   | (s.lcl & ~p.lcl)
                   | (s.talk & ~p.talk);                          // [R10]

  // ****************************************************************
  // Interrupt status byte
  // ****************************************************************
  always_comb begin
    status                 = 8'h00;                     // [R24]
    status[`GTLP_ST_RBV]   = s.rbv;                     // [R12]
    status[`GTLP_ST_DCLR]  = q_r.dclr;                  // [R13]
    status[`GTLP_ST_SPOLL] = s.spoll;                   // [R14]
    status[`GTLP_ST_TALK]  = s.talk;                    // [R15]
    status[`GTLP_ST_EOI]   = q_r.eoi;                   // [R16]
    status[`GTLP_ST_HS]    = q_r.hs;                    // [R17]
    status[`GTLP_ST_LCL]   = s.lcl;
  end

  // ****************************************************************
  // Core next state
  // ****************************************************************
  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = pins;
    q_nxt.s2 = q_r.s1;
    q_nxt.p  = q_r.s2;

    // Latches written on the rising edge of their strobes
    if (ctl_rise) begin
      q_nxt.ctrl = s.cpu_d;                             // [R5]
    end
    if (tx_rise) begin
      q_nxt.tx = s.cpu_d;                               // [R20]
    end
    if (rbv_rise) begin
      q_nxt.rx = s.dio;                                 // [R21]
    end

    // Read data register follows whichever read strobe is low
    if (!s.strb_rx_n) begin
      q_nxt.rd = q_r.rx;                                // [R21]
    end else if (!s.strb_st_n) begin
      q_nxt.rd = status;                                // [R24]
    end

    // Sticky flags: the clear comes first so a new event wins
    if (st_rise) begin
      q_nxt.irq  = 1'b0;                                // [R11]
      q_nxt.dclr = 1'b0;
      q_nxt.eoi  = 1'b0;
    end
    if (src_event) begin
      q_nxt.irq = 1'b1;                                 // [R10]
    end
    if (s.dclr & ~p.dclr) begin
      q_nxt.dclr = 1'b1;                                // [R13]
    end
    if (s.eoi & ~p.eoi) begin
      q_nxt.eoi = 1'b1;                                 // [R16]
    end
    if (q_r.ctrl[`GTLP_CTL_NBA] & ~q_nxt.ctrl[`GTLP_CTL_NBA]) begin
      q_nxt.hs = 1'b0;                                  // [R17]
    end
    if (hs_set) begin
      q_nxt.hs = 1'b1;                                  // [R17]
    end

    // Controller clock divider
    if (q_r.div == 5'h00) begin
      q_nxt.div  = 5'(`GTLP_HALF_CNT - 1);              // [R18]
      q_nxt.sclk = ~q_r.sclk;
    end else begin
      q_nxt.div = q_r.div - 5'h01;
    end

    // Reload the address when the switches move
    if (sh.start) begin
      q_nxt.need = 1'b0;
    end
    if ((s.addr != p.addr) || (s.lonly != p.lonly)) begin
      q_nxt.need = 1'b1;                                // [R3]
    end
  end

  // State register
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      q_r      <= '0;
      q_r.s1   <= pins_idle;                            // [R19]
      q_r.s2   <= pins_idle;
      q_r.p    <= pins_idle;
      q_r.ctrl <= `GTLP_CTL_RST;                        // [R19]
      q_r.need <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************************************
  // Address shifter
  // ****************************************************************
  assign sh_idle    = ~sh.busy;
  assign sh.tick    = (q_r.div == 5'h00);
  assign sh.sclk    = q_r.sclk;
  assign sh.start   = q_r.need & sh_idle;
  assign sh.pattern = {1'b0, `GTLP_TALK_ONLY, s.lonly, s.addr}; // [R4]

  gtlp_addr_shifter u_shifter (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .sh       (sh.shifter)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cpu_data_out         = q_r.rd;
  assign cpu_data_oe_out      = ~s.strb_rx_n | ~s.strb_st_n;        // [R21]
  assign irq_out              = q_r.irq;
  assign bus_data_out         = q_r.tx;                              // [R20]
  assign ready_next_n_out     = q_r.ctrl[`GTLP_CTL_RFNM];            // [R22]
  assign listen_mode_out      = q_r.ctrl[`GTLP_CTL_LMODE];           // [R6]
  assign service_request_out  = q_r.ctrl[`GTLP_CTL_RSV];             // [R7] [R23]
  assign new_byte_avail_n_out = q_r.ctrl[`GTLP_CTL_NBA];             // [R9]
  assign bic_clk_out          = q_r.sclk;                            // [R18]
  assign addr_ser_data_out    = sh.ser_data;
  assign addr_ser_load_out    = sh.ser_strobe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  chk_irq_from_rbv: assert property ( // [R10]
    (rbv_rise && !q_r.ctrl[`GTLP_CTL_LEN]) |=> irq_out)
    else $error("interrupt missed on received byte");

  chk_irq_masked_rbv: assert property ( // [R8]
    $rose(irq_out) |-> $past(src_event))
    else $error("interrupt raised without an enabled source");

  chk_irq_ack_read: assert property ( // [R11]
    (st_rise && !src_event) |=> !irq_out)
    else $error("status read did not clear interrupt");

  chk_rx_capture: assert property ( // [R21]
    rbv_rise |=> q_r.rx == $past(s.dio))
    else $error("input latch did not capture bus data");

  chk_rx_read_drive: assert property ( // [R21]
    !s.strb_rx_n |-> cpu_data_oe_out ##1 cpu_data_out == $past(q_r.rx))
    else $error("input latch not driven during read");

  chk_tx_latch_write: assert property ( // [R20]
    tx_rise |=> bus_data_out == $past(s.cpu_d))
    else $error("output latch did not capture data");

  chk_ready_bit_write: assert property ( // [R5]
    ctl_rise |=> ready_next_n_out == $past(s.cpu_d[`GTLP_CTL_RFNM]))
    else $error("ready bit not written");

  chk_srq_bit_write: assert property ( // [R23]
    ctl_rise |=> service_request_out == $past(s.cpu_d[`GTLP_CTL_RSV]))
    else $error("service request bit not written");

  chk_hs_set_dav: assert property ( // [R17]
    hs_set |=> status[`GTLP_ST_HS])
    else $error("handshake bit not set on data valid");

  chk_eoi_sticky: assert property ( // [R16]
    (s.eoi && !p.eoi) |=> q_r.eoi)
    else $error("end-or-identify bit not set");

  chk_bic_clk_half: assert property ( // [R18]
    $changed(bic_clk_out) |=> !$changed(bic_clk_out) [*8])
    else $error("controller clock half period too short");

endmodule

`default_nettype wire

// ### verification/gtlp_bus_model.sv
`default_nettype none

// ****************************************************************
// Bus controller stand-in
// ****************************************************************
module gtlp_bus_model (
  input  wire logic       mclk_in,
  input  wire logic       ready_next_n_in,
  input  wire logic       bic_clk_in,
  input  wire logic       ser_data_in,
  input  wire logic       ser_load_in,
  output logic      [6:0] ev_out,
  output logic      [7:0] dio_out,
  output logic      [7:0] addr_seen_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sr_r;

  // Quiet lines at start
  initial begin
    ev_out = 7'h00;
    dio_out = 8'h00;
    addr_seen_out = 8'h00;
    sr_r = 8'h00;
  end

  // Address bits arrive lsb first on the controller clock
  always @(posedge bic_clk_in) sr_r <= {ser_data_in, sr_r[7:1]};

  // Pattern taken whole at the load pulse
  always @(posedge mclk_in) if (ser_load_in) addr_seen_out <= sr_r;

  // Raise or drop one event line just after an edge
  task automatic set_ev(input int idx, input logic v);
    @(posedge mclk_in);
    #2 ev_out[idx] = v;
  endtask

  // Offer a byte once the host is ready; source acts unaddressed, talk-only
  task automatic send_byte(input logic [7:0] d, output bit ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < 200 && !ok; i++) begin
      @(posedge mclk_in);
      ok = (ready_next_n_in === 1'b0);
    end
    if (ok) begin
      #2 dio_out = d;
      ev_out[0] = 1'b1;
    end
  endtask

  // End the byte; released data lines show the inverse
  task automatic end_byte;
    @(posedge mclk_in);
    #2 ev_out[0] = 1'b0;
    dio_out = ~dio_out;
  endtask
endmodule

`default_nettype wire

// ### verification/test_gtlp_port.sv
`default_nettype none

module test_gtlp_port;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic       mclk;
  logic       rst_n;
  logic       ctl_n;
  logic       txw_n;
  logic       st_n;
  logic       rxr_n;
  logic [7:0] cpu_d;
  logic [4:0] sw;
  logic       lonly;
  logic [7:0] rd_d;
  logic       oe;
  logic       irq;
  logic [7:0] tx_q;
  logic       rdy_n;
  logic       lmode;
  logic       srq;
  logic       nba_n;
  logic       bclk;
  logic       brst_n;
  logic       sdat;
  logic       sload;
  logic [6:0] ev;
  logic [7:0] dio;
  logic [7:0] seen;
  logic [7:0] ctl_v;
  logic       p;
  int         n_mismatch;
  int         checks;
  int         i;
  int         a;
  int         b;
  bit         ok;
  int         ev_i[5] = '{1, 2, 3, 4, 5};
  logic [7:0] st_e[5] = '{8'h02, 8'h40, 8'h04, 8'h08, 8'h10};
  logic [4:0] irq_e = 5'h0B;
  logic [4:0] stk_e = 5'h11;

  assign ctl_v = {4'h0, rdy_n, lmode, srq, nba_n};

  // ****************************************************************
  // Design and far side
  // ****************************************************************
  gtlp_port u_gtlp_port (
    .mclk_in(mclk), .rst_n_in(rst_n),
    .ctl_write_strobe_n_in(ctl_n), .output_latch_write_strobe_n_in(txw_n),
    .status_read_strobe_n_in(st_n), .input_latch_read_strobe_n_in(rxr_n),
    .cpu_data_in(cpu_d), .cpu_data_out(rd_d), .cpu_data_oe_out(oe), .irq_out(irq),
    .address_switch_lsb_in(sw[0]), .address_switch_mid_in(sw[3:1]),
    .address_switch_msb_in(sw[4]), .listen_only_switch_in(lonly),
    .received_byte_valid_in(ev[0]), .device_clear_in(ev[1]), .local_in(ev[2]),
    .serial_poll_in(ev[3]), .talker_active_in(ev[4]), .eoi_in(ev[5]), .dav_in(ev[6]),
    .bus_data_in(dio), .bus_data_out(tx_q), .ready_next_n_out(rdy_n),
    .listen_mode_out(lmode), .service_request_out(srq), .new_byte_avail_n_out(nba_n),
    .bic_clk_out(bclk), .bic_reset_n_out(brst_n), .addr_ser_data_out(sdat),
    .addr_ser_load_out(sload)
  );

  gtlp_bus_model bm (
    .mclk_in(mclk), .ready_next_n_in(rdy_n), .bic_clk_in(bclk), .ser_data_in(sdat),
    .ser_load_in(sload), .ev_out(ev), .dio_out(dio), .addr_seen_out(seen)
  );

  // ****************************************************************
  // Clock, watchdog and tasks
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Cut a hang short
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic ctl, input logic [7:0] d);
    cpu_d = d;
    if (ctl) ctl_n = 1'b0;
    else txw_n = 1'b0;
    tick(4);
    ctl_n = 1'b1;
    txw_n = 1'b1;
    tick(6);
  endtask

  task automatic rd_chk(input logic st, input logic [7:0] exp);
    if (st) st_n = 1'b0;
    else rxr_n = 1'b0;
    tick(5);
    check({7'h00, oe}, 8'h01);
    check(rd_d, exp);
    st_n = 1'b1;
    rxr_n = 1'b1;
    tick(5);
    check({7'h00, oe}, 8'h00);
  endtask

  // Bounded wait for a given shifted address pattern
  task automatic wait_addr(input logic [7:0] exp);
    for (a = 0; a < 3000 && seen !== exp; a++) tick(1);
    if (a == 3000) begin
      n_mismatch++;
      close_out();
    end else begin
      check(seen, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done, mismatches %0d", s, n_mismatch);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    ctl_n = 1'b1;
    txw_n = 1'b1;
    st_n = 1'b1;
    rxr_n = 1'b1;
    cpu_d = 8'h00;
    sw = 5'h15;
    lonly = 1'b1;
    n_mismatch = 0;
    checks = 0;
    tick(15);
    check({ctl_v[3:0], irq, brst_n, 2'h0}, 8'h90);
    check(tx_q, 8'h00);
    check({7'h00, oe}, 8'h00);
    tick(1);
    rst_n = 1'b1;
    tick(4);
    check({7'h00, brst_n}, 8'h01);
    done("reset");

    // Address pattern and controller clock
    wait_addr(8'h35);
    sw = 5'h0A;
    lonly = 1'b0;
    wait_addr(8'h0A);
    a = -1;
    b = -1;
    p = bclk;
    for (i = 0; i < 200 && b < 0; i++) begin
      tick(1);
      if (bclk && !p) begin
        if (a < 0) a = i;
        else b = i;
      end
      p = bclk;
    end
    check(8'(b - a), 8'h20);
    done("address");

    // Control latch bits
    wr(1'b1, 8'h06);
    check(ctl_v, 8'h06);
    wr(1'b1, 8'h11);
    check(ctl_v, 8'h09);
    wr(1'b1, 8'h10);
    check(ctl_v, 8'h01);
    done("control");

    // Received byte, unmasked then masked
    bm.send_byte(8'h5A, ok);
    check({7'h00, ok}, 8'h01);
    tick(8);
    check({7'h00, irq}, 8'h01);
    rd_chk(1'b1, 8'h01);
    check({7'h00, irq}, 8'h00);
    rd_chk(1'b0, 8'h5A);
    bm.end_byte();
    wr(1'b1, 8'h18);
    bm.send_byte(8'hC3, ok);
    tick(8);
    check({7'h00, irq}, 8'h00);
    rd_chk(1'b0, 8'hC3);
    bm.end_byte();
    tick(8);
    done("receive");

    // Each controller event: interrupt, sticky or live status, acknowledge
    for (i = 0; i < 5; i++) begin
      bm.set_ev(ev_i[i], 1'b1);
      tick(8);
      check({7'h00, irq}, {7'h00, irq_e[i]});
      bm.set_ev(ev_i[i], 1'b0);
      tick(8);
      rd_chk(1'b1, stk_e[i] ? st_e[i] : 8'h00);
      rd_chk(1'b1, 8'h00);
      bm.set_ev(ev_i[i], 1'b1);
      tick(8);
      rd_chk(1'b1, st_e[i]);
      check({7'h00, irq}, 8'h00);
      bm.set_ev(ev_i[i], 1'b0);
    end
    done("events");

    // Handshake flag set by data valid while talking, cleared by new byte
    bm.set_ev(4, 1'b1);
    bm.set_ev(6, 1'b1);
    tick(3);
    bm.set_ev(6, 1'b0);
    tick(8);
    rd_chk(1'b1, 8'h28);
    wr(1'b1, 8'h08);
    rd_chk(1'b1, 8'h08);
    bm.set_ev(4, 1'b0);
    done("handshake");

    // Transmit latch drives the bus lines
    wr(1'b0, 8'hA5);
    check(tx_q, 8'hA5);
    wr(1'b0, 8'h3C);
    check(tx_q, 8'h3C);
    done("transmit");

    // Reset in mid-run
    rst_n = 1'b0;
    tick(2);
    check({ctl_v[3:0], irq, brst_n, 2'h0}, 8'h90);
    check(tx_q, 8'h00);
    rst_n = 1'b1;
    tick(8);
    check(ctl_v, 8'h09);
    check({7'h00, oe}, 8'h00);
    done("second reset");
    close_out();
  end
endmodule

`default_nettype wire
